// ===== core/ddzc_params.svh
// constants and register map of the delay, zero pad and integrator-comb front end
// Overview of operation
// (R1) order: zero pad, decimator, compensation stage
// (R2) pulse_shaping_fir keeps rate, one out per in
// (R3) output stage: no decimation or by two
// (R4) host sets output decimate-by-two for chip rate
// (R5) host picks decimation for twice chip rate
// (R6) system clocks chain at zero-padded rate
// (R7) eight-entry delay memory, counter write pointer
// (R8) each coarse step adds one input sample
// (R9) zero pad inserts zeros up to clock rate
// (R10) fine offset places zeros after sync pulse
// (R11) offsets double buffered, loaded on register sync
// (R12) 3-bit coarse offset per side A/B
// (R13) 3-bit fine offset per side A/B
// (R14) shared interpolation setting: 1, 2, 4, 8
// (R15) shared selector for fine insertion sync
// (R16) shared selector for offset update sync
// (R17) six stages, decimation 4 through 32
// (R18) separate decimator for I and Q
// (R19) second I/Q decimator pair for side B
// (R20) selector picks one of eight sync sources
// (R21) sample then N-1 zeros, one per clock
// (R22) reset clears offsets and write counter
`ifndef DDZC_PARAMS_SVH
`define DDZC_PARAMS_SVH
`define DDZC_ADDR_COARSE  8'h00
`define DDZC_ADDR_FINE    8'h04
`define DDZC_ADDR_INTERP  8'h08
`define DDZC_ADDR_SYNCSEL 8'h0C
`define DDZC_ADDR_DECIM   8'h10
`define DDZC_ADDR_STATUS  8'h14
`define DDZC_FLD_A        0
`define DDZC_FLD_B        4
`define DDZC_FLD_FINE_A   8
`define DDZC_FLD_FINE_B   12
`define DDZC_FLD_WPTR     16
`define DDZC_RST_OFS      3'h0
`define DDZC_RST_INTERP   3'h0
`define DDZC_RST_SEL      3'h0
`define DDZC_RST_DECIM    5'h07
`define DDZC_DECIM_MIN    5'h03
`define DDZC_CIC_STAGES   6
`define DDZC_CIC_GROWTH   30
`define DDZC_MEM_DEPTH    8
`endif

// ===== core/ddzc_pkg.sv
// shared types of the delay, zero pad and integrator-comb front end
package ddzc_pkg;
    typedef logic [2:0] ddzc_ofs_t;
    typedef struct packed {
        ddzc_ofs_t coarse_a;
        ddzc_ofs_t coarse_b;
        ddzc_ofs_t fine_a;
        ddzc_ofs_t fine_b;
    } ddzc_offsets_t;
endpackage

// ===== core/ddzc_stream_if.sv
// sample stream between the front end modules
`timescale 1ns/10ps
interface ddzc_stream_if #(parameter int W = 32);
    logic         valid;
    logic [W-1:0] data;
    modport src (output valid, output data);
    modport snk (input valid, input data);
endinterface

// ===== core/ddzc_delay_mem.sv
// eight-entry delay memory with counter write pointer and offset read pointer
`timescale 1ns/10ps
`include "ddzc_params.svh"
module ddzc_delay_mem #(
    parameter int W     = 32,
    parameter int DEPTH = `DDZC_MEM_DEPTH,
    parameter int AW    = 3
) (
    input  wire logic          clk,
    input  wire logic          rstn,
    ddzc_stream_if.snk         wr,
    input  wire logic [AW-1:0] offset,
    output logic      [W-1:0]  rd_data,
    output logic      [AW-1:0] wr_ptr
);
    logic [W-1:0]  mem [DEPTH];
    logic [AW-1:0] rd_addr;

    // newest entry sits at wr_ptr-1; larger offset reaches older samples
    assign rd_addr = wr_ptr - AW'(1) - offset; // R8 R12

    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            wr_ptr  <= '0; // R22
            rd_data <= '0;
        end else begin
            if (wr.valid) begin
                wr_ptr <= wr_ptr + AW'(1); // R7
            end
            rd_data <= mem[rd_addr];
        end
    end

    // cleared so reads of unwritten entries never feed unknowns to the integrators
    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            for (int k = 0; k < DEPTH; k++) begin
                mem[k] <= '0;
            end
        end else if (wr.valid) begin
            mem[wr_ptr] <= wr.data; // R7
        end
    end

    a_newest_read: assert property (@(posedge clk) disable iff (!rstn) // R7 R8
        (wr.valid && offset == '0) ##1 (offset == '0) |=> rd_data == $past(wr.data, 2))
        else $error("newest sample not read back at zero offset");
endmodule

// ===== core/ddzc_cic.sv
// one six-stage integrator-comb decimator rail
`timescale 1ns/10ps
`include "ddzc_params.svh"
module ddzc_cic #(
    parameter int W  = 16,
    parameter int GW = W + `DDZC_CIC_GROWTH
) (
    input  wire logic       clk,
    input  wire logic       rstn,
    input  wire logic [4:0] decim,
    ddzc_stream_if.snk      din,
    ddzc_stream_if.src      dout
);
    localparam int N = `DDZC_CIC_STAGES;
    logic [GW-1:0] integ [N];
    logic [GW-1:0] dly   [N];
    logic [GW-1:0] comb  [N+1];
    logic [4:0]    cnt;
    logic [4:0]    ratio_m1;
    logic          take;

    // ratios below four are raised to four
    assign ratio_m1 = (decim < `DDZC_DECIM_MIN) ? `DDZC_DECIM_MIN : decim; // R17
    assign take = din.valid && (cnt == ratio_m1);

    always_comb begin
        comb[0] = integ[N-1];
        for (int k = 0; k < N; k++) begin
            comb[k+1] = comb[k] - dly[k];
        end
    end

    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            for (int k = 0; k < N; k++) begin
                integ[k] <= '0;
                dly[k]   <= '0;
            end
            cnt        <= '0;
            dout.valid <= 1'b0;
            dout.data  <= '0;
        end else begin
            dout.valid <= take;
            if (din.valid) begin
                integ[0] <= integ[0] + GW'($signed(din.data)); // R17
                for (int k = 1; k < N; k++) begin
                    integ[k] <= integ[k] + integ[k-1];
                end
                cnt <= take ? 5'h00 : cnt + 5'h01;
            end
            if (take) begin
                for (int k = 0; k < N; k++) begin
                    dly[k] <= comb[k];
                end
                dout.data <= comb[N];
            end
        end
    end

    a_decim_gap: assert property (@(posedge clk) disable iff (!rstn) // R17
        dout.valid |=> !dout.valid [*3])
        else $error("decimated output faster than one in four");
endmodule

// ===== core/ddzc_top.sv
// channel front end: delay memory, zero pad and integrator-comb decimators
//
// Chosen here: the register addresses and register access over APB.
`timescale 1ns/10ps
`include "ddzc_params.svh"
module ddzc_top #(
    parameter int W  = 16,
    parameter int GW = W + `DDZC_CIC_GROWTH
) (
    input  wire logic          pclk,
    input  wire logic          presetn,
    input  wire logic [7:0]    paddr,
    input  wire logic          psel,
    input  wire logic          penable,
    input  wire logic          pwrite,
    input  wire logic [31:0]   pwdata,
    output logic      [31:0]   prdata,
    output logic               pready,
    output logic               pslverr,
    input  wire logic          in_valid,
    input  wire logic [W-1:0]  in_i_a,
    input  wire logic [W-1:0]  in_q_a,
    input  wire logic [W-1:0]  in_i_b,
    input  wire logic [W-1:0]  in_q_b,
    input  wire logic [7:0]    sync_in,
    output logic               cic_valid_a,
    output logic               cic_valid_b,
    output logic      [GW-1:0] cic_i_a,
    output logic      [GW-1:0] cic_q_a,
    output logic      [GW-1:0] cic_i_b,
    output logic      [GW-1:0] cic_q_b
);
    ddzc_pkg::ddzc_offsets_t buf_ofs;
    ddzc_pkg::ddzc_offsets_t act_ofs;
    ddzc_pkg::ddzc_ofs_t     interp_code;
    ddzc_pkg::ddzc_ofs_t     fine_sel;
    ddzc_pkg::ddzc_ofs_t     reg_sel;
    logic [4:0]              cic_decim;
    logic [2:0]              wr_ptr_a;
    logic [2:0]              cnt_a;
    logic [2:0]              cnt_b;
    logic [2*W-1:0]          mem_a;
    logic [2*W-1:0]          mem_b;
    logic [W-1:0]            pad [4];

    // ---------------- register bus ----------------
    logic setup;
    logic wr_acc;
    logic hit_coarse;
    logic hit_fine;
    logic hit_interp;
    logic hit_sel;
    logic hit_decim;
    logic hit_status;
    logic mapped;
    logic [31:0] rd_mux;

    assign setup      = psel && !penable;
    assign wr_acc     = psel && penable && pwrite;
    assign hit_coarse = paddr == `DDZC_ADDR_COARSE;
    assign hit_fine   = paddr == `DDZC_ADDR_FINE;
    assign hit_interp = paddr == `DDZC_ADDR_INTERP;
    assign hit_sel    = paddr == `DDZC_ADDR_SYNCSEL;
    assign hit_decim  = paddr == `DDZC_ADDR_DECIM;
    assign hit_status = paddr == `DDZC_ADDR_STATUS;
    assign mapped     = hit_coarse || hit_fine || hit_interp || hit_sel
                        || hit_decim || hit_status;
    assign pready     = 1'b1;
    assign pslverr    = psel && penable && !mapped;

    always_comb begin
        rd_mux = 32'h0000_0000;
        if (hit_coarse) begin
            rd_mux[`DDZC_FLD_A +: 3] = buf_ofs.coarse_a;
            rd_mux[`DDZC_FLD_B +: 3] = buf_ofs.coarse_b;
        end else if (hit_fine) begin
            rd_mux[`DDZC_FLD_A +: 3] = buf_ofs.fine_a;
            rd_mux[`DDZC_FLD_B +: 3] = buf_ofs.fine_b;
        end else if (hit_interp) begin
            rd_mux[`DDZC_FLD_A +: 3] = interp_code;
        end else if (hit_sel) begin
            rd_mux[`DDZC_FLD_A +: 3] = fine_sel;
            rd_mux[`DDZC_FLD_B +: 3] = reg_sel;
        end else if (hit_decim) begin
            rd_mux[4:0] = cic_decim;
        end else if (hit_status) begin
            rd_mux[`DDZC_FLD_A +: 3]      = act_ofs.coarse_a;
            rd_mux[`DDZC_FLD_B +: 3]      = act_ofs.coarse_b;
            rd_mux[`DDZC_FLD_FINE_A +: 3] = act_ofs.fine_a;
            rd_mux[`DDZC_FLD_FINE_B +: 3] = act_ofs.fine_b;
            rd_mux[`DDZC_FLD_WPTR +: 3]   = wr_ptr_a;
        end
    end

    // read data captured in the setup cycle, so no wait states are needed
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            prdata <= 32'h0000_0000;
        end else if (setup && !pwrite) begin
            prdata <= rd_mux;
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            buf_ofs     <= '0; // R22
            interp_code <= `DDZC_RST_INTERP;
            fine_sel    <= `DDZC_RST_SEL;
            reg_sel     <= `DDZC_RST_SEL;
            cic_decim   <= `DDZC_RST_DECIM;
        end else if (wr_acc) begin
            // shadow copies take writes at any time
            if (hit_coarse) begin
                buf_ofs.coarse_a <= pwdata[`DDZC_FLD_A +: 3]; // R11 R12
                buf_ofs.coarse_b <= pwdata[`DDZC_FLD_B +: 3]; // R12
            end
            if (hit_fine) begin
                buf_ofs.fine_a <= pwdata[`DDZC_FLD_A +: 3]; // R13
                buf_ofs.fine_b <= pwdata[`DDZC_FLD_B +: 3]; // R13
            end
            if (hit_interp) begin
                interp_code <= pwdata[`DDZC_FLD_A +: 3]; // R14
            end
            if (hit_sel) begin
                fine_sel <= pwdata[`DDZC_FLD_A +: 3]; // R15
                reg_sel  <= pwdata[`DDZC_FLD_B +: 3]; // R16
            end
            if (hit_decim) begin
                cic_decim <= pwdata[4:0]; // R17
            end
        end
    end

    // ---------------- sync selection and double buffer ----------------
    logic fine_sync;
    logic reg_sync;

    assign fine_sync = sync_in[fine_sel]; // R15 R20
    assign reg_sync  = sync_in[reg_sel]; // R16 R20

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            act_ofs <= '0; // R22
        end else if (reg_sync) begin
            act_ofs <= buf_ofs; // R11
        end
    end

    // ---------------- delay memories, one per side ----------------
    ddzc_stream_if #(.W(2*W)) wr_a ();
    ddzc_stream_if #(.W(2*W)) wr_b ();

    assign wr_a.valid = in_valid;
    assign wr_a.data  = {in_q_a, in_i_a};
    assign wr_b.valid = in_valid;
    assign wr_b.data  = {in_q_b, in_i_b};

    ddzc_delay_mem #(.W(2*W)) u_mem_a (
        .clk     (pclk),
        .rstn    (presetn),
        .wr      (wr_a),
        .offset  (act_ofs.coarse_a), // R8
        .rd_data (mem_a),
        .wr_ptr  (wr_ptr_a)
    );

    ddzc_delay_mem #(.W(2*W)) u_mem_b (
        .clk     (pclk),
        .rstn    (presetn),
        .wr      (wr_b),
        .offset  (act_ofs.coarse_b), // R8
        .rd_data (mem_b),
        .wr_ptr  ()
    );

    // ---------------- zero pad ----------------
    // interp_code holds N-1 (0, 1, 3, 7) and doubles as the phase mask
    logic       slot_a;
    logic       slot_b;
    logic [2:0] next_cnt_a;
    logic [2:0] next_cnt_b;

    assign slot_a = cnt_a == 3'h0;
    assign slot_b = cnt_b == 3'h0;
    // a fine sync puts the next sample fine_x clocks later
    assign next_cnt_a = fine_sync ? (3'h0 - act_ofs.fine_a) & interp_code // R10 R13
                                  : (cnt_a + 3'h1) & interp_code; // R21
    assign next_cnt_b = fine_sync ? (3'h0 - act_ofs.fine_b) & interp_code // R10 R13
                                  : (cnt_b + 3'h1) & interp_code; // R21

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            cnt_a <= 3'h0;
            cnt_b <= 3'h0;
            for (int k = 0; k < 4; k++) begin
                pad[k] <= '0;
            end
        end else begin
            cnt_a  <= next_cnt_a;
            cnt_b  <= next_cnt_b;
            // sample in its slot, zeros in between, one output per clock
            pad[0] <= slot_a ? mem_a[W-1:0] : '0; // R9 R21
            pad[1] <= slot_a ? mem_a[2*W-1:W] : '0; // R9 R21
            pad[2] <= slot_b ? mem_b[W-1:0] : '0; // R9 R21
            pad[3] <= slot_b ? mem_b[2*W-1:W] : '0; // R9 R21
        end
    end

    // ---------------- decimators, I and Q of each side ----------------
    logic          dec_valid [4];
    logic [GW-1:0] dec_data  [4];

    for (genvar r = 0; r < 4; r++) begin : g_rail
        ddzc_stream_if #(.W(W))  cin ();
        ddzc_stream_if #(.W(GW)) cout ();
        // the padded stream runs at the clock rate, valid every cycle
        assign cin.valid    = 1'b1; // R6
        assign cin.data     = pad[r]; // R1
        assign dec_valid[r] = cout.valid;
        assign dec_data[r]  = cout.data;
        ddzc_cic #(.W(W), .GW(GW)) u_cic ( // R18 R19
            .clk   (pclk),
            .rstn  (presetn),
            .decim (cic_decim),
            .din   (cin),
            .dout  (cout)
        );
    end

    // decimated rails go on to compensation_fir, then pulse_shaping_fir
    assign cic_valid_a = dec_valid[0]; // R1
    assign cic_i_a     = dec_data[0]; // R2 R3
    assign cic_q_a     = dec_data[1];
    assign cic_valid_b = dec_valid[2]; // R19
    assign cic_i_b     = dec_data[2];
    assign cic_q_b     = dec_data[3];

    // ---------------- checks ----------------
    sequence s_quiet_by8;
        (!fine_sync && interp_code == 3'h7) [*8];
    endsequence

    a_offset_hold: assert property (@(posedge pclk) disable iff (!presetn) // R11
        !reg_sync |=> act_ofs == $past(act_ofs))
        else $error("active offsets changed without register sync");

    a_offset_load: assert property (@(posedge pclk) disable iff (!presetn) // R11 R16
        reg_sync |=> act_ofs == $past(buf_ofs))
        else $error("register sync did not load buffered offsets");

    a_zero_fill: assert property (@(posedge pclk) disable iff (!presetn) // R9 R21
        !slot_a |=> pad[0] == '0 && pad[1] == '0)
        else $error("non-zero sample outside insert slot");

    a_sample_pass: assert property (@(posedge pclk) disable iff (!presetn) // R21
        slot_b |=> pad[2] == $past(mem_b[W-1:0]))
        else $error("side B sample lost in its slot");

    a_fine_place: assert property (@(posedge pclk) disable iff (!presetn) // R10
        fine_sync |=> cnt_a == ((3'h0 - $past(act_ofs.fine_a)) & $past(interp_code)))
        else $error("fine offset misplaced the insert slot");

    a_pad_ratio: assert property (@(posedge pclk) disable iff (!presetn) // R9
        slot_a ##0 s_quiet_by8 |=> slot_a)
        else $error("by-eight pad does not repeat every eight clocks");

    a_slot_gap: assert property (@(posedge pclk) disable iff (!presetn) // R9 R14
        (slot_a && interp_code == 3'h7 && !fine_sync) ##1 (!fine_sync) |-> !slot_a)
        else $error("zero slot skipped at by-eight pad");

    a_bus_error: assert property (@(posedge pclk) disable iff (!presetn)
        (psel && penable && !mapped) |-> pslverr ##1 (buf_ofs == $past(buf_ofs)))
        else $error("unmapped access not refused");

    a_coarse_store: assert property (@(posedge pclk) disable iff (!presetn) // R11 R12
        (wr_acc && hit_coarse) |=> buf_ofs.coarse_a == $past(pwdata[2:0])
            && buf_ofs.coarse_b == $past(pwdata[6:4]))
        else $error("coarse offset write not stored");

    a_fine_store: assert property (@(posedge pclk) disable iff (!presetn) // R11 R13
        (wr_acc && hit_fine) |=> buf_ofs.fine_a == $past(pwdata[2:0])
            && buf_ofs.fine_b == $past(pwdata[6:4]))
        else $error("fine offset write not stored");

    a_shadow_only: assert property (@(posedge pclk) disable iff (!presetn) // R11
        !(wr_acc && (hit_coarse || hit_fine)) |=> buf_ofs == $past(buf_ofs))
        else $error("buffered offsets changed without a write");

    a_interp_store: assert property (@(posedge pclk) disable iff (!presetn) // R14
        (wr_acc && hit_interp) |=> interp_code == $past(pwdata[2:0]))
        else $error("interpolation setting not stored");

    a_sel_store: assert property (@(posedge pclk) disable iff (!presetn) // R15 R16
        (wr_acc && hit_sel) |=> fine_sel == $past(pwdata[2:0])
            && reg_sel == $past(pwdata[6:4]))
        else $error("sync selectors not stored");

    a_decim_store: assert property (@(posedge pclk) disable iff (!presetn) // R17
        (wr_acc && hit_decim) |=> cic_decim == $past(pwdata[4:0]))
        else $error("decimation setting not stored");

    a_sync_pick: assert property (@(posedge pclk) disable iff (!presetn) // R20
        $onehot(sync_in) |-> reg_sync == (sync_in == (8'h01 << reg_sel))
            && fine_sync == (sync_in == (8'h01 << fine_sel)))
        else $error("sync selector picked the wrong source");

    a_fine_place_b: assert property (@(posedge pclk) disable iff (!presetn) // R10 R13
        fine_sync |=> cnt_b == ((3'h0 - $past(act_ofs.fine_b)) & $past(interp_code)))
        else $error("side B fine offset misplaced the insert slot");

    a_zero_fill_b: assert property (@(posedge pclk) disable iff (!presetn) // R9 R21
        !slot_b |=> pad[2] == '0 && pad[3] == '0)
        else $error("non-zero side B sample outside insert slot");

    a_sample_pass_a: assert property (@(posedge pclk) disable iff (!presetn) // R21
        slot_a |=> pad[0] == $past(mem_a[W-1:0]) && pad[1] == $past(mem_a[2*W-1:W]))
        else $error("side A sample lost in its slot");

    a_pad_full: assert property (@(posedge pclk) disable iff (!presetn) // R14 R21
        interp_code == 3'h0 |=> slot_a && slot_b)
        else $error("unpadded stream skipped a sample");

    sequence s_quiet_by2;
        (!fine_sync && interp_code == 3'h1) [*2];
    endsequence

    a_pad_by2: assert property (@(posedge pclk) disable iff (!presetn) // R9 R14
        slot_a ##0 s_quiet_by2 |=> slot_a)
        else $error("by-two pad does not repeat every two clocks");

    sequence s_quiet_by4;
        (!fine_sync && interp_code == 3'h3) [*4];
    endsequence

    a_pad_by4: assert property (@(posedge pclk) disable iff (!presetn) // R9 R14
        slot_a ##0 s_quiet_by4 |=> slot_a)
        else $error("by-four pad does not repeat every four clocks");

    a_ptr_step: assert property (@(posedge pclk) disable iff (!presetn) // R7
        in_valid |=> wr_ptr_a == $past(wr_ptr_a) + 3'h1)
        else $error("write pointer did not advance on a sample");

    sequence s_ratio4;
        (cic_decim == 5'h03) [*4];
    endsequence

    a_decim_period: assert property (@(posedge pclk) disable iff (!presetn) // R17
        cic_valid_a ##0 s_ratio4 |=> cic_valid_a)
        else $error("ratio four output not every four clocks");
endmodule

// ===== verification/ddzc_src_model.sv
// upstream sample source standing in for the mixer stage
`timescale 1ns/10ps
module ddzc_src_model (
    input  wire logic        pclk,
    input  wire logic        presetn,
    input  wire logic [3:0]  period,
    input  wire logic [15:0] val_i_a,
    input  wire logic [15:0] val_q_a,
    input  wire logic [15:0] val_i_b,
    input  wire logic [15:0] val_q_b,
    output logic             in_valid,
    output logic [15:0]      in_i_a,
    output logic [15:0]      in_q_a,
    output logic [15:0]      in_i_b,
    output logic [15:0]      in_q_b
);
    logic [3:0] cnt;
    // one sample every period clocks, zero period stops the stream
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            cnt      <= 4'h0;
            in_valid <= 1'b0;
        end else if (period == 4'h0) begin
            cnt      <= 4'h0;
            in_valid <= 1'b0;
        end else begin
            in_valid <= (cnt == 4'h0);
            cnt      <= (cnt + 4'h1 >= period) ? 4'h0 : cnt + 4'h1;
        end
    end
    // lines carry the inverse between samples so stale data never looks valid
    assign in_i_a = in_valid ? val_i_a : ~val_i_a;
    assign in_q_a = in_valid ? val_q_a : ~val_q_a;
    assign in_i_b = in_valid ? val_i_b : ~val_i_b;
    assign in_q_b = in_valid ? val_q_b : ~val_q_b;
endmodule

// ===== verification/test_ddc_delay_zero_pad_cic.sv
// self-checking bench of the channel front end
`timescale 1ns/10ps
`define CHK(nm, e, g) begin checks++; if ((g) !== (e)) begin err_count++; \
    $display("MISMATCH %s exp %0h seen %0h", nm, e, g); end end
module test_ddc_delay_zero_pad_cic;
    logic        pclk = 1'b0;
    logic        presetn = 1'b0;
    logic [7:0]  paddr = 8'h00;
    logic        psel = 1'b0;
    logic        penable = 1'b0;
    logic        pwrite = 1'b0;
    logic [31:0] pwdata = 32'h0;
    logic [31:0] prdata;
    logic        pready;
    logic        pslverr;
    logic        in_valid;
    logic [15:0] in_i_a, in_q_a, in_i_b, in_q_b;
    logic [7:0]  sync_in = 8'h00;
    logic        cic_valid_a, cic_valid_b;
    logic [45:0] cic_i_a, cic_q_a, cic_i_b, cic_q_b;
    logic [3:0]  period = 4'h0;
    logic [15:0] v_ia = 16'h0, v_qa = 16'h0, v_ib = 16'h0, v_qb = 16'h0;
    int          err_count = 0;
    int          checks = 0;

    always #12.5 pclk = ~pclk;

    ddzc_top #(.W(16), .GW(46)) DUT (
        .pclk(pclk), .presetn(presetn), .paddr(paddr), .psel(psel),
        .penable(penable), .pwrite(pwrite), .pwdata(pwdata), .prdata(prdata),
        .pready(pready), .pslverr(pslverr), .in_valid(in_valid),
        .in_i_a(in_i_a), .in_q_a(in_q_a), .in_i_b(in_i_b), .in_q_b(in_q_b),
        .sync_in(sync_in), .cic_valid_a(cic_valid_a), .cic_valid_b(cic_valid_b),
        .cic_i_a(cic_i_a), .cic_q_a(cic_q_a), .cic_i_b(cic_i_b), .cic_q_b(cic_q_b));

    ddzc_src_model src (
        .pclk(pclk), .presetn(presetn), .period(period), .val_i_a(v_ia),
        .val_q_a(v_qa), .val_i_b(v_ib), .val_q_b(v_qb), .in_valid(in_valid),
        .in_i_a(in_i_a), .in_q_a(in_q_a), .in_i_b(in_i_b), .in_q_b(in_q_b));

    task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] wd,
                       output logic [31:0] rd, output logic err);
        @(posedge pclk);
        psel    <= 1'b1;
        penable <= 1'b0;
        pwrite  <= wr;
        paddr   <= a;
        pwdata  <= wd;
        @(posedge pclk);
        penable <= 1'b1;
        do begin
            @(posedge pclk);
        end while (pready !== 1'b1);
        rd      = prdata;
        err     = pslverr;
        psel    <= 1'b0;
        penable <= 1'b0;
    endtask

    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        logic [31:0] r;
        logic e;
        apb(1'b1, a, d, r, e);
    endtask

    task automatic rd_chk(input logic [7:0] a, input logic [31:0] m, input logic [31:0] x);
        logic [31:0] r;
        logic e;
        apb(1'b0, a, 32'h0, r, e);
        `CHK("register", x, r & m)
    endtask

    task automatic sync_pulse(input int b);
        @(posedge pclk);
        sync_in <= 8'h01 << b;
        @(posedge pclk);
        sync_in <= 8'h00;
        @(posedge pclk);
    endtask

    task automatic wait_valid(input int k);
        int n;
        n = 0;
        while (k > 0 && n < 5000) begin
            @(negedge pclk);
            n++;
            if (cic_valid_a === 1'b1) k--;
        end
        if (n >= 5000) `CHK("valid wait", 1'b0, 1'b1)
    endtask

    task automatic t_reset();
        logic [31:0] r;
        logic e;
        rd_chk(8'h00, 32'hFFFFFFFF, 32'h0);
        rd_chk(8'h04, 32'hFFFFFFFF, 32'h0);
        rd_chk(8'h08, 32'hFFFFFFFF, 32'h0);
        rd_chk(8'h0C, 32'hFFFFFFFF, 32'h0);
        rd_chk(8'h10, 32'hFFFFFFFF, 32'h7);
        rd_chk(8'h14, 32'hFFFFFFFF, 32'h0);
        wr(8'h14, 32'h7777);
        rd_chk(8'h14, 32'hFFFFFFFF, 32'h0);
        apb(1'b0, 8'h18, 32'h0, r, e);
        `CHK("unmapped err", 1'b1, e)
        `CHK("unmapped data", 32'h0, r)
        `CHK("ready", 1'b1, pready)
        $display("test reset done");
    endtask

    task automatic t_sync_sel();
        logic [31:0] cur, nxt;
        cur = 32'h0;
        for (int s = 0; s < 8; s++) begin
            nxt = {17'h0, 3'(s ^ 2), 1'b0, 3'(s ^ 5), 1'b0, 3'(7 - s), 1'b0, 3'(s)};
            wr(8'h0C, {25'h0, 3'(s), 4'h0});
            wr(8'h00, {25'h0, nxt[6:4], 1'b0, nxt[2:0]});
            wr(8'h04, {25'h0, nxt[14:12], 1'b0, nxt[10:8]});
            sync_pulse((s + 1) % 8);
            rd_chk(8'h14, 32'h7777, cur);
            sync_pulse(s);
            rd_chk(8'h14, 32'h7777, nxt);
            cur = nxt;
        end
        $display("test sync select done");
    endtask

    task automatic t_pad_gain();
        logic [45:0] g;
        int n;
        v_ia <= 16'd3;
        v_qa <= 16'd5;
        v_ib <= 16'd7;
        v_qb <= 16'd11;
        wr(8'h10, 32'h7);
        for (int c = 0; c < 4; c++) begin
            n = 1 << c;
            wr(8'h08, 32'(n - 1));
            period <= 4'(n);
            wait_valid(12);
            g = 46'((8 / n) * 32768);
            `CHK("cic i a", 46'd3 * g, cic_i_a)
            `CHK("cic q a", 46'd5 * g, cic_q_a)
            `CHK("cic i b", 46'd7 * g, cic_i_b)
            `CHK("cic q b", 46'd11 * g, cic_q_b)
            `CHK("cic valid b", 1'b1, cic_valid_b)
        end
        $display("test zero pad done");
    endtask

    task automatic t_ratio();
        logic [4:0] dv [3] = '{5'd1, 5'd3, 5'd31};
        int ex [3] = '{4, 4, 32};
        int n;
        for (int k = 0; k < 3; k++) begin
            wr(8'h10, {27'h0, dv[k]});
            wait_valid(3);
            n = 0;
            do begin
                @(negedge pclk);
                n++;
            end while (cic_valid_a !== 1'b1 && n < 100);
            `CHK("ratio", ex[k], n)
        end
        $display("test ratio done");
    endtask

    task automatic t_coarse();
        wr(8'h08, 32'h0);
        wr(8'h10, 32'h3);
        period <= 4'h1;
        v_ia   <= 16'h0;
        v_ib   <= 16'h0;
        wr(8'h00, 32'h30);
        wr(8'h04, 32'h0);
        sync_pulse(7);
        rd_chk(8'h14, 32'h7777, 32'h30);
        wait_valid(12);
        @(posedge pclk);
        v_ia <= 16'd100;
        v_ib <= 16'd100;
        do wait_valid(1); while (cic_i_a === 46'h0 && err_count == 0);
        `CHK("later side b", 1'b1, cic_i_b < cic_i_a)
        $display("test coarse delay done");
    endtask

    task automatic close_out();
        $display("checks %0d mismatches %0d", checks, err_count);
        if (err_count == 0 && checks > 0) $display("== PASSED ==");
        else $display("== FAILED ==");
        $finish;
    endtask

    initial begin
        #(25 * 50000);
        err_count++;
        close_out();
    end

    initial begin
        repeat (5) @(posedge pclk);
        presetn <= 1'b1;
        t_reset();
        t_sync_sel();
        t_pad_gain();
        t_ratio();
        t_coarse();
        close_out();
    end
endmodule
